// [rtl/dpm_direct_move.sv]
// Purpose: Discrete command inputs and arrival outputs for direct point moves.
// Assumes: Command pins and encoder pins are asynchronous to clk.
// Notes: The motion stage executes the move and reports the home mark.
//
// Summary of operation
// RL1: Seven positions, each own input and output.
// RL2: Input n starts move to entry n.
// RL3: Output n asserted on reaching entry n.
// RL4: Host raises only the one wanted input.
// RL5: Host avoids push moves in three-point pattern.
// RL6: Arrival judged from encoder-derived coordinate count.
// RL7: Speed from entry field, default rated.
// RL8: Ramps from entry fields, default rated.
// RL9: Three-point inputs target entries zero to two.
// RL10: Rear command before homing homes first.
// RL11: New move clears all arrival outputs.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module dpm_direct_move (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [6:0] direct_move_cmd,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic home_mark,
    output dpm_pkg::dpm_motion_t motion,
    output logic [6:0] arrived_flag,
    output logic rear_end_detected,
    output logic front_end_detected,
    output logic midpoint_detected,
    output logic home_done
);

    typedef enum logic [1:0] {
        S_IDLE,
        S_LOAD,
        S_HOME,
        S_MOVE
    } dpm_state_t;

    dpm_state_t state_r;
    dpm_state_t state_nxt;
    dpm_pkg::dpm_pattern_t pattern_r;
    dpm_pkg::dpm_entry_t entry_q;
    dpm_pkg::dpm_motion_t motion_nxt;
    logic [6:0] cmd_s1_r, cmd_s2_r, cmd_prev_r;
    logic [2:0] enc_s1_r, enc_s2_r;
    logic enc_a_prev_r, enc_b_prev_r, home_prev_r;
    logic [31:0] coord_r;
    logic [31:0] band_r;
    logic [31:0] target_r;
    logic [2:0] pend_idx_r;
    logic [6:0] arrived_r;
    logic [6:0] arrived_nxt;
    logic home_done_r;
    logic [31:0] stat_q_r;
    logic tbl_sel_r;
    logic [6:0] cmd_rise, cmd_ok;
    logic [2:0] acc_idx;
    logic accept, home_rise, in_pos;
    logic enc_step, enc_up;
    logic signed [32:0] pos_err;
    logic [32:0] pos_abs;
    logic is_tbl, tbl_ok;
    logic [2:0] tbl_idx;
    logic [1:0] tbl_fld;
    logic [31:0] stat_word;
    logic [31:0] tbl_q;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // The pipelines run through reset, so a pin level held across reset is no false edge.
    always_ff @(posedge clk) begin
        cmd_s1_r <= direct_move_cmd;
        cmd_s2_r <= cmd_s1_r;
        cmd_prev_r <= cmd_s2_r;
        enc_s1_r <= {home_mark, enc_b, enc_a};
        enc_s2_r <= enc_s1_r;
        enc_a_prev_r <= enc_s2_r[0];
        enc_b_prev_r <= enc_s2_r[1];
        home_prev_r <= enc_s2_r[2];
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    assign cmd_rise = cmd_s2_r & ~cmd_prev_r; // RL2
    assign home_rise = enc_s2_r[2] & ~home_prev_r;

    generate
        for (genvar g = 0; g < dpm_pkg::NUM_POS; g++) begin : g_cmd
            if (g < dpm_pkg::THREE_PT_CNT) begin : g_low
                // Before homing, the three-point pattern takes only the rear command.
                assign cmd_ok[g] = cmd_rise[g] & ((pattern_r == dpm_pkg::PAT_SEVEN) |
                                   home_done_r | (g == 0)); // RL9 RL10
            end else begin : g_high
                assign cmd_ok[g] = cmd_rise[g] & (pattern_r == dpm_pkg::PAT_SEVEN); // RL1 RL9
            end
        end
    endgenerate

    always_comb begin
        acc_idx = 3'h0;
        for (int i = dpm_pkg::NUM_POS - 1; i >= 0; i--) begin
            if (cmd_ok[i]) begin
                acc_idx = i[2:0];
            end
        end
    end

    assign accept = (|cmd_ok) && (state_r == S_IDLE || state_r == S_MOVE); // RL2

    // ----------------------------------------------------------------
    // Coordinate count from the quadrature encoder
    // ----------------------------------------------------------------
    assign enc_step = (enc_s2_r[0] ^ enc_a_prev_r) ^ (enc_s2_r[1] ^ enc_b_prev_r);
    assign enc_up = enc_s2_r[0] ^ enc_b_prev_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            coord_r <= dpm_pkg::COORD_HOME;
        end else if (state_r == S_HOME && home_rise) begin
            coord_r <= dpm_pkg::COORD_HOME;
        end else if (enc_step) begin
            coord_r <= enc_up ? coord_r + 32'h0000_0001 : coord_r - 32'h0000_0001; // RL6
        end
    end

    assign pos_err = $signed({coord_r[31], coord_r}) - $signed({target_r[31], target_r});
    assign pos_abs = pos_err[32] ? 33'(-pos_err) : 33'(pos_err);
    assign in_pos = (pos_abs <= {1'b0, band_r}); // RL6

    // ----------------------------------------------------------------
    // Move sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        arrived_nxt = arrived_r;
        motion_nxt = motion;
        motion_nxt.start = 1'b0;
        motion_nxt.home = 1'b0;
        case (state_r)
            S_LOAD: begin
                if (!home_done_r) begin
                    motion_nxt.home = 1'b1; // RL10
                    state_nxt = S_HOME;
                end else begin
                    motion_nxt.start = 1'b1; // RL2
                    motion_nxt.entry = pend_idx_r;
                    motion_nxt.target = entry_q.position; // RL2
                    motion_nxt.speed = entry_q.speed; // RL7
                    motion_nxt.accel = entry_q.accel; // RL8
                    motion_nxt.decel = entry_q.decel; // RL8
                    state_nxt = S_MOVE;
                end
            end
            S_HOME: begin
                if (home_rise) begin
                    state_nxt = S_LOAD; // RL10
                end
            end
            S_MOVE: begin
                if (in_pos) begin
                    arrived_nxt = 7'(1 << pend_idx_r); // RL3 RL11
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        if (accept) begin
            arrived_nxt = 7'h00; // RL11
            state_nxt = S_LOAD;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            arrived_r <= 7'h00;
            motion <= '0;
            pend_idx_r <= 3'h0;
            target_r <= 32'h0000_0000;
            home_done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            arrived_r <= arrived_nxt;
            motion <= motion_nxt;
            if (accept) begin
                pend_idx_r <= acc_idx;
            end
            if (motion_nxt.start) begin
                target_r <= entry_q.position;
            end
            if (state_r == S_HOME && home_rise) begin
                home_done_r <= 1'b1;
            end
        end
    end

    assign arrived_flag = (pattern_r == dpm_pkg::PAT_SEVEN) ? arrived_r : 7'h00; // RL1 RL3
    assign rear_end_detected = (pattern_r == dpm_pkg::PAT_THREE) & arrived_r[0]; // RL9
    assign front_end_detected = (pattern_r == dpm_pkg::PAT_THREE) & arrived_r[1]; // RL9
    assign midpoint_detected = (pattern_r == dpm_pkg::PAT_THREE) & arrived_r[2]; // RL9
    assign home_done = home_done_r;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    assign is_tbl = reg_addr[dpm_pkg::TBL_FLAG_BIT];
    assign tbl_idx = reg_addr[dpm_pkg::TBL_ENTRY_LSB +: 3];
    assign tbl_fld = reg_addr[dpm_pkg::TBL_FIELD_LSB +: 2];
    assign tbl_ok = is_tbl && (tbl_idx < 3'(dpm_pkg::NUM_POS)) && (reg_addr[1:0] == 2'h0);
    assign stat_word = (reg_addr == dpm_pkg::ADDR_CTRL) ? {31'h0, pattern_r} :
                       (reg_addr == dpm_pkg::ADDR_STATUS) ?
                       ({17'h0, arrived_r, 2'h0, (state_r != S_IDLE), home_done_r,
                         1'b0, pend_idx_r}) :
                       (reg_addr == dpm_pkg::ADDR_COORD) ? coord_r :
                       (reg_addr == dpm_pkg::ADDR_BAND) ? band_r : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pattern_r <= dpm_pkg::PAT_SEVEN;
            band_r <= dpm_pkg::BAND_RST;
            stat_q_r <= 32'h0000_0000;
            tbl_sel_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == dpm_pkg::ADDR_CTRL) begin
                pattern_r <= dpm_pkg::dpm_pattern_t'(reg_wdata[dpm_pkg::CTRL_PATTERN_BIT]);
            end
            if (reg_wr && reg_addr == dpm_pkg::ADDR_BAND) begin
                band_r <= reg_wdata;
            end
            stat_q_r <= reg_rd ? stat_word : 32'h0000_0000;
            tbl_sel_r <= reg_rd && tbl_ok;
        end
    end

    assign reg_rdata = tbl_sel_r ? tbl_q : stat_q_r;

    dpm_pos_table u_table (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(reg_wr && tbl_ok),
        .wr_idx(tbl_idx),
        .wr_fld(tbl_fld),
        .wr_data(reg_wdata),
        .bus_idx(tbl_idx),
        .bus_fld(tbl_fld),
        .bus_q(tbl_q),
        .mv_idx(accept ? acc_idx : pend_idx_r),
        .mv_q(entry_q)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_ready_accept;
        accept && home_done_r && state_r != S_HOME;
    endsequence

    property p_start_entry;
        s_ready_accept ##1 !accept |=> motion.start && motion.entry == $past(pend_idx_r);
    endproperty
    a_start_entry: assert property (p_start_entry) else $error("move did not start"); // RL2

    property p_seven_only;
        (pattern_r == dpm_pkg::PAT_SEVEN && |arrived_r) |->
            arrived_flag == 7'(1 << pend_idx_r) &&
            {midpoint_detected, front_end_detected, rear_end_detected} == 3'h0;
    endproperty
    a_seven_only: assert property (p_seven_only) else $error("pattern outputs mixed"); // RL1

    property p_arrive;
        (state_r == S_MOVE && in_pos && !accept && pattern_r == dpm_pkg::PAT_SEVEN)
            |=> arrived_flag == 7'(1 << pend_idx_r);
    endproperty
    a_arrive: assert property (p_arrive) else $error("arrival flag missing"); // RL3

    property p_by_coord;
        $rose(|arrived_r) |-> $past(in_pos) && $past(state_r) == S_MOVE;
    endproperty
    a_by_coord: assert property (p_by_coord) else $error("arrival without position"); // RL6

    property p_speed;
        motion.start |-> motion.speed == $past(entry_q.speed);
    endproperty
    a_speed: assert property (p_speed) else $error("speed not from table"); // RL7

    property p_ramps;
        motion.start |-> motion.accel == $past(entry_q.accel) &&
                         motion.decel == $past(entry_q.decel);
    endproperty
    a_ramps: assert property (p_ramps) else $error("ramps not from table"); // RL8

    property p_three_idx;
        (pattern_r == dpm_pkg::PAT_THREE && accept) |-> acc_idx <= dpm_pkg::IDX_MID;
    endproperty
    a_three_idx: assert property (p_three_idx) else $error("bad three point target"); // RL9

    sequence s_unhomed_rear;
        accept && !home_done_r && acc_idx == dpm_pkg::IDX_REAR;
    endsequence

    property p_home_first;
        s_unhomed_rear ##1 !accept |=> motion.home && !motion.start;
    endproperty
    a_home_first: assert property (p_home_first) else $error("home not first"); // RL10

    property p_clear;
        accept |=> arrived_r == 7'h00 ##0 $onehot0(arrived_r);
    endproperty
    a_clear: assert property (p_clear) else $error("arrival not cleared"); // RL11

    property p_onehot;
        $onehot0(arrived_r);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one arrival"); // RL11

endmodule : dpm_direct_move

// [rtl/dpm_pkg.sv]
// Purpose: Shared constants and types of the direct point move logic.
// Assumes: Registers are 32-bit words at byte addresses on a plain port.
// Notes: The position table holds seven entries of four fields each.
package dpm_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_POS = 7;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int FLD_W = 16;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COORD = 8'h08;
    localparam logic [7:0] ADDR_BAND = 8'h0C;
    localparam int TBL_FLAG_BIT = 7;
    localparam int TBL_ENTRY_LSB = 4;
    localparam int TBL_FIELD_LSB = 2;
    localparam logic [1:0] FLD_POSITION = 2'h0;
    localparam logic [1:0] FLD_SPEED = 2'h1;
    localparam logic [1:0] FLD_ACCEL = 2'h2;
    localparam logic [1:0] FLD_DECEL = 2'h3;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_PATTERN_BIT = 0;
    localparam int STAT_IDX_LSB = 0;
    localparam int STAT_HOME_BIT = 4;
    localparam int STAT_BUSY_BIT = 5;
    localparam int STAT_ARR_LSB = 8;
    localparam logic [31:0] BAND_RST = 32'h0000_000A;
    localparam logic [31:0] COORD_HOME = 32'h0000_0000;
    localparam logic [15:0] RATED_SPEED = 16'h01F4;
    localparam logic [15:0] RATED_ACCEL = 16'h001E;
    localparam logic [2:0] IDX_REAR = 3'h0;
    localparam logic [2:0] IDX_FRONT = 3'h1;
    localparam logic [2:0] IDX_MID = 3'h2;
    localparam int THREE_PT_CNT = 3;

    // Speed is in mm/s; acceleration and deceleration in 0.01 G steps.
    typedef struct packed {
        logic [31:0] position;
        logic [15:0] speed;
        logic [15:0] accel;
        logic [15:0] decel;
    } dpm_entry_t;

    typedef struct packed {
        logic start;
        logic home;
        logic [2:0] entry;
        logic [31:0] target;
        logic [15:0] speed;
        logic [15:0] accel;
        logic [15:0] decel;
    } dpm_motion_t;

    typedef enum logic {
        PAT_SEVEN,
        PAT_THREE
    } dpm_pattern_t;

endpackage : dpm_pkg

// [rtl/dpm_pos_table.sv]
// Purpose: Position table memory with a bus port and a move-load port.
// Assumes: Writes touch one field of one entry at a time.
// Notes: Both read ports return data from a register one cycle later.
`timescale 1ns/1ps
module dpm_pos_table #(
    parameter int DEPTH = dpm_pkg::NUM_POS,
    parameter logic [15:0] DEF_SPEED = dpm_pkg::RATED_SPEED,
    parameter logic [15:0] DEF_ACCEL = dpm_pkg::RATED_ACCEL
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [1:0] wr_fld,
    input wire logic [31:0] wr_data,
    input wire logic [2:0] bus_idx,
    input wire logic [1:0] bus_fld,
    output logic [31:0] bus_q,
    input wire logic [2:0] mv_idx,
    output dpm_pkg::dpm_entry_t mv_q
);

    dpm_pkg::dpm_entry_t mem [DEPTH];
    dpm_pkg::dpm_entry_t bus_ent;
    logic [31:0] bus_word;

    assign bus_ent = mem[bus_idx];
    assign bus_word = (bus_fld == dpm_pkg::FLD_POSITION) ? bus_ent.position :
                      (bus_fld == dpm_pkg::FLD_SPEED) ? {16'h0000, bus_ent.speed} :
                      (bus_fld == dpm_pkg::FLD_ACCEL) ? {16'h0000, bus_ent.accel} :
                      {16'h0000, bus_ent.decel};

    // ----------------------------------------------------------------
    // Storage, reset to rated speed and rated ramps
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (sys_rst) begin
                mem[i].position <= 32'h0000_0000;
                mem[i].speed <= DEF_SPEED; // RL7
                mem[i].accel <= DEF_ACCEL; // RL8
                mem[i].decel <= DEF_ACCEL; // RL8
            end else if (wr_en && wr_idx == i[2:0]) begin
                case (wr_fld)
                    dpm_pkg::FLD_POSITION: mem[i].position <= wr_data;
                    dpm_pkg::FLD_SPEED: mem[i].speed <= wr_data[15:0];
                    dpm_pkg::FLD_ACCEL: mem[i].accel <= wr_data[15:0];
                    default: mem[i].decel <= wr_data[15:0];
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_q <= 32'h0000_0000;
            mv_q <= '0;
        end else begin
            bus_q <= bus_word;
            mv_q <= mem[mv_idx];
        end
    end

endmodule : dpm_pos_table

// [tb/dpm_stage_model.sv]
// Purpose: Behavioural actuator stage that feeds the encoder and home mark pins.
// Assumes: One encoder count per four clocks; count up when a leads b.
// Notes: Home return walks back to count zero, then pulses the home mark.
`timescale 1ns/1ps
module dpm_stage_model (
    input wire logic clk,
    input wire dpm_pkg::dpm_motion_t motion,
    output logic enc_a,
    output logic enc_b,
    output logic home_mark
);
    // ----------------------------------------------------------------
    // Stage state
    // ----------------------------------------------------------------
    int pos = 0;
    int tgt = 0;
    int div = 0;
    int mark_cnt = 0;
    bit homing = 1'b0;

    initial begin
        enc_a = 1'b0;
        enc_b = 1'b0;
        home_mark = 1'b0;
    end

    // ----------------------------------------------------------------
    // Motion, home search and quadrature output
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (motion.home === 1'b1) begin
            homing = 1'b1;
            tgt = 0;
        end
        if (motion.start === 1'b1) begin
            tgt = $signed(motion.target);
        end
        div = (div + 1) % 4;
        if (div == 0 && pos < tgt) begin
            pos = pos + 1;
        end else if (div == 0 && pos > tgt) begin
            pos = pos - 1;
        end
        if (homing && div == 0 && pos == tgt) begin
            homing = 1'b0;
            mark_cnt = 4;
        end
        home_mark <= (mark_cnt > 0);
        if (mark_cnt > 0) begin
            mark_cnt = mark_cnt - 1;
        end
        enc_a <= pos[1] ^ pos[0];
        enc_b <= pos[1];
    end
endmodule : dpm_stage_model

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the direct point move block.
// Assumes: The stage model supplies the encoder and home mark pins.
// Notes: The bench plays the host and drives the command pins.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [6:0] cmd = 7'h00;
    logic enc_a;
    logic enc_b;
    logic home_mark;
    dpm_pkg::dpm_motion_t motion;
    logic [6:0] arr;
    wire logic [2:0] det;
    logic home_done;
    int miscompares = 0;
    int n_tests = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    dpm_direct_move dut_u (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .direct_move_cmd(cmd),
        .enc_a(enc_a), .enc_b(enc_b), .home_mark(home_mark), .motion(motion),
        .arrived_flag(arr), .rear_end_detected(det[0]), .front_end_detected(det[1]),
        .midpoint_detected(det[2]), .home_done(home_done)
    );

    dpm_stage_model stage_u (
        .clk(clk), .motion(motion), .enc_a(enc_a), .enc_b(enc_b), .home_mark(home_mark)
    );

    // ----------------------------------------------------------------
    // Checking, bus and wait tasks
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(nm, reg_rdata, e);
    endtask : rchk

    function automatic logic [7:0] ta(input int n, input logic [1:0] f);
        return 8'h80 + 8'(n * 16) + {4'h0, f, 2'h0};
    endfunction : ta

    function automatic logic [31:0] tg(input int n);
        return 32'h10 + 32'(n * 12);
    endfunction : tg

    task automatic wait_for(input int sel);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 1000 && !hit; i++) begin
            @(negedge clk);
            case (sel)
                0: hit = (motion.start === 1'b1);
                1: hit = (motion.home === 1'b1);
                default: hit = ((arr | {4'h0, det}) !== 7'h00);
            endcase
        end
        if (!hit) begin
            check("wait", 32'h0, 32'h1);
            final_report();
        end
    endtask : wait_for

    task automatic quiet(input string nm);
        int c;
        c = 0;
        repeat (40) begin
            @(negedge clk);
            if (motion.start === 1'b1 || motion.home === 1'b1) begin
                c++;
            end
        end
        check(nm, 32'(c), 32'h0);
    endtask : quiet

    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        cmd <= 7'h00;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
    endtask : do_reset

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic move_to(input int n, input logic [6:0] m, input bit homed, input bit three);
        logic [31:0] oh;
        oh = 32'(1 << n);
        @(posedge clk);
        cmd <= m;
        if (!homed) begin
            wait_for(1);
            check("home_done", {31'h0, home_done}, 32'h0);
        end
        wait_for(0);
        check("cleared", {25'h0, arr}, 32'h0);
        check("entry", {29'h0, motion.entry}, 32'(n));
        check("target", motion.target, tg(n));
        check("speed", {16'h0, motion.speed}, 32'h100 + 32'(n));
        check("accel", {16'h0, motion.accel}, {16'h0, dpm_pkg::RATED_ACCEL});
        check("decel", {16'h0, motion.decel}, n == 6 ? 32'h5 : 32'h1E);
        @(posedge clk);
        cmd <= 7'h00;
        wait_for(2);
        check("arrived", {25'h0, arr}, three ? 32'h0 : oh);
        check("detected", {29'h0, det}, three ? oh : 32'h0);
    endtask : move_to

    task automatic t_defaults();
        check("outs", {21'h0, home_done, det, arr}, 32'h0);
        rchk("ctrl", dpm_pkg::ADDR_CTRL, 32'h0);
        rchk("band", dpm_pkg::ADDR_BAND, dpm_pkg::BAND_RST);
        rchk("spd3", ta(3, dpm_pkg::FLD_SPEED), {16'h0, dpm_pkg::RATED_SPEED});
        rchk("acc5", ta(5, dpm_pkg::FLD_ACCEL), 32'h1E);
        rchk("dec6", ta(6, dpm_pkg::FLD_DECEL), 32'h1E);
        wr(ta(7, dpm_pkg::FLD_SPEED), 32'h55);
        wr(8'h10, 32'h55);
        rchk("entry7", ta(7, dpm_pkg::FLD_SPEED), 32'h0);
        rchk("unmapped", 8'h10, 32'h0);
    endtask : t_defaults

    task automatic t_table();
        for (int n = 0; n < 7; n++) begin
            wr(ta(n, dpm_pkg::FLD_POSITION), tg(n));
            wr(ta(n, dpm_pkg::FLD_SPEED), 32'h100 + 32'(n));
        end
        wr(ta(6, dpm_pkg::FLD_DECEL), 32'h5);
        wr(dpm_pkg::ADDR_BAND, 32'h2);
        rchk("spd6", ta(6, dpm_pkg::FLD_SPEED), 32'h106);
        rchk("dec6w", ta(6, dpm_pkg::FLD_DECEL), 32'h5);
        rchk("acc6", ta(6, dpm_pkg::FLD_ACCEL), 32'h1E);
        rchk("pos2", ta(2, dpm_pkg::FLD_POSITION), tg(2));
    endtask : t_table

    task automatic t_three();
        do_reset();
        wr(dpm_pkg::ADDR_CTRL, 32'h1);
        rchk("ctrl3", dpm_pkg::ADDR_CTRL, 32'h1);
        t_table();
        @(posedge clk);
        cmd <= 7'h02;
        quiet("refuse_front");
        move_to(0, 7'h01, 1'b0, 1'b1);
        for (int n = 1; n < 3; n++) begin
            move_to(n, 7'(1 << n), 1'b1, 1'b1);
        end
        @(posedge clk);
        cmd <= 7'h40;
        quiet("refuse_six");
        rchk("coord", dpm_pkg::ADDR_COORD, tg(2));
    endtask : t_three

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        t_defaults();
        t_table();
        move_to(3, 7'h08, 1'b0, 1'b0);
        check("homed", {31'h0, home_done}, 32'h1);
        rchk("status", dpm_pkg::ADDR_STATUS, 32'h0000_0813);
        for (int n = 0; n < 7; n++) begin
            move_to(n, 7'(1 << n), 1'b1, 1'b0);
        end
        @(posedge clk);
        cmd <= 7'h20;
        wait_for(0);
        @(posedge clk);
        cmd <= 7'h00;
        repeat (20) @(posedge clk);
        move_to(2, 7'h04, 1'b1, 1'b0);
        move_to(4, 7'h30, 1'b1, 1'b0);
        t_three();
        final_report();
    end
endmodule : tb_top
